// *** include/dhm_pkg.sv ***
// Package for the drive health monitor: map, fields, codes and timing.
// Assumes a 50 MHz APB clock.
`default_nettype none
package dhm_pkg;
  // Timing, each time in its own unit, then derived counts
  localparam int unsigned DHM_CLK_NS          = 20;
  localparam int unsigned DHM_TICK_MS         = 1000;
  localparam int unsigned DHM_TICK_CYCLES     = DHM_TICK_MS * 1000000 / DHM_CLK_NS;
  localparam int unsigned DHM_STALL_ONLINE_MS = 220;
  localparam int unsigned DHM_STALL_FULL_MS   = 455;
  localparam int unsigned DHM_STALL_ONLINE_CY = DHM_STALL_ONLINE_MS * 1000000 / DHM_CLK_NS;
  localparam int unsigned DHM_STALL_FULL_CY   = DHM_STALL_FULL_MS * 1000000 / DHM_CLK_NS;
  localparam int unsigned DHM_SCHED_HOURS     = 2;
  localparam int unsigned DHM_TEMP_MINUTES    = 10;
  localparam logic [12:0] DHM_SCHED_TICKS     = 13'(DHM_SCHED_HOURS * 3600);
  localparam logic [12:0] DHM_TEMP_TICKS      = 13'(DHM_TEMP_MINUTES * 60);
  // Register byte offsets
  localparam logic [7:0] DHM_A_CTRL   = 8'h00;
  localparam logic [7:0] DHM_A_CMD    = 8'h04;
  localparam logic [7:0] DHM_A_IOPS   = 8'h08;
  localparam logic [7:0] DHM_A_FTHR   = 8'h0C;
  localparam logic [7:0] DHM_A_PTHR   = 8'h10;
  localparam logic [7:0] DHM_A_REFT   = 8'h14;
  localparam logic [7:0] DHM_A_SENSE  = 8'h18;
  localparam logic [7:0] DHM_A_STAT   = 8'h1C;
  localparam logic [7:0] DHM_A_LOGSEL = 8'h20;
  localparam logic [7:0] DHM_A_LOGDAT = 8'h24;
  // Command bits
  localparam int DHM_CMD_REZERO = 0;
  localparam int DHM_CMD_CLEAR  = 1;
  // Reset values
  localparam logic [7:0]  DHM_CTRL_RST = 8'h44;
  localparam logic [15:0] DHM_IOPS_RST = 16'h0400;
  localparam logic [15:0] DHM_FTHR_RST = 16'h0010;
  localparam logic [7:0]  DHM_PTHR_RST = 8'h08;
  localparam logic [7:0]  DHM_TEMP_FIXED_C = 8'h41;
  // Log pages and sense codes
  localparam logic [7:0] DHM_LOG_TIME = 8'h3E;
  localparam logic [7:0] DHM_LOG_TEMP = 8'h0D;
  localparam logic [7:0] DHM_KEY_RECOV = 8'h01;
  localparam logic [7:0] DHM_ASC_PRED  = 8'h5D;
  localparam logic [7:0] DHM_ASC_TEMP  = 8'h0B;
  localparam logic [7:0] DHM_ASCQ_TEMP = 8'h01;
  localparam logic [7:0] DHM_ASC_ROUND = 8'h37;
  localparam logic [7:0] DHM_ASCQ_ZERO = 8'h00;

  typedef struct packed {
    logic [3:0] report_method_field;
    logic       spare;
    logic       enable_temp_warning_bit;
    logic       online_only_bit;
    logic       disable_exception_bit;
  } dhm_ctrl_s;

  typedef struct packed {
    logic [7:0] fru;
    logic [7:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } dhm_sense_s;

  typedef enum logic [1:0] {
    DHM_P_IDLE = 2'b00,
    DHM_P_WAIT = 2'b01,
    DHM_P_RUN  = 2'b10
  } dhm_pass_e;
endpackage
`default_nettype wire

// *** src/dhm_drive_health_monitor.sv ***
// Drive health monitor: error-rate tracking, measurement schedule,
// thermal trip points and sense reporting behind an APB slave.
// Assumes op/error strobes, idle and measurement handshakes are on pclk.
// Functional notes
// R1: exception-disable bit stops all predictive monitoring
// R2: online-only bit skips offline measurement work
// R3: gather online data with normal operations
// R4: forced pass measures, saves, restarts two-hour timer
// R5: log page 3E returns time to next pass
// R6: pass every two hours, waits idle, uninterruptible
// R7: stall bounded 220ms online-only, 455ms full
// R8: predictive failure reported as 01-5Dxx per method
// R9: reported code survives resets and power cycles; the 01-3700 rounding code is not saved
// R10: interval counter ends interval at operation count
// R11: failure counter records errors within interval
// R12: errors above threshold mean unacceptable interval
// R13: both counters clear after every verdict
// R14: history counter up on bad, down on good
// R15: history reaching threshold signals predictive failure
// R16: sample temperature at power-up, then every ten minutes
// R17: over trip limit raises warning 01-0B01
// R18: current temperature goes into FRU field
// R19: warning gated by enable bit, reported per method
// R20: first trip point fixed at 65 C
// R21: host reference trip point clamped to 65, reported
// R22: compare both trip points at each sample
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dhm_drive_health_monitor #(
  parameter int unsigned NUM_ATTR     = 4,
  parameter int unsigned CW           = 16,
  parameter int unsigned HW           = 8,
  parameter int unsigned TICK_CYCLES  = dhm_pkg::DHM_TICK_CYCLES,
  parameter int unsigned STALL_ONLINE = dhm_pkg::DHM_STALL_ONLINE_CY,
  parameter int unsigned STALL_FULL   = dhm_pkg::DHM_STALL_FULL_CY
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_ATTR-1:0]  op_strobe,
  input  wire logic [NUM_ATTR-1:0]  err_strobe,
  input  wire logic                 host_idle,
  input  wire logic                 meas_done,
  input  wire logic [7:0]           temp_c,
  input  wire dhm_pkg::dhm_sense_s  nv_sense_in,
  input  wire logic                 nv_valid_in,
  output logic                      meas_req,
  output logic                      meas_offline,
  output dhm_pkg::dhm_sense_s       nv_sense_out,
  output logic                      nv_save,
  output logic                      sense_valid,
  output logic                      stall_over
);
  import dhm_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(STALL_FULL + 1);

  dhm_ctrl_s           ctrl;
  logic [15:0]         iops;
  logic [15:0]         fthr;
  logic [7:0]          pthr;
  logic [7:0]          ref_temp;
  logic [7:0]          log_sel;
  logic [7:0]          temp_last;
  logic                temp_warn;
  logic                clamp_flag;
  logic [CW-1:0]       intv_cnt [NUM_ATTR];
  logic [CW-1:0]       fail_cnt [NUM_ATTR];
  logic [HW-1:0]       hist_cnt [NUM_ATTR];
  logic [NUM_ATTR-1:0] pred_flag;
  logic [NUM_ATTR-1:0] pred_new;
  logic [NUM_ATTR-1:0] verdict_end;
  logic [NUM_ATTR-1:0] verdict_bad;
  logic [CW-1:0]       next_fail [NUM_ATTR];
  logic [TW-1:0]       tick_div;
  logic                tick;
  logic [12:0]         sched_secs;
  logic [12:0]         temp_secs;
  logic                temp_first;
  logic                temp_sample;
  logic                pass_pend;
  dhm_pass_e           pass_state;
  logic [SW-1:0]       stall_cnt;
  logic                stall_hit;
  logic                restore_pend;
  logic                mon_on;
  logic                report_en;
  logic                apb_wr;
  logic                apb_setup;
  logic                rezero_req;
  logic                clear_req;
  logic                ref_wr;
  logic [31:0]         next_rdata;
  logic                next_err;

  // Saturating history update, floor at zero and ceiling at all ones
  function automatic logic [HW-1:0] dhm_hist_next(input logic [HW-1:0] h, input logic bad);
    if (bad) begin
      return (h == '1) ? h : HW'(h + 1'b1);
    end
    return (h == '0) ? h : HW'(h - 1'b1);
  endfunction

  // Lowest attribute index with a flag set
  function automatic logic [7:0] dhm_first_idx(input logic [NUM_ATTR-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NUM_ATTR - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  assign mon_on     = !ctrl.disable_exception_bit; // R1
  assign report_en  = ctrl.report_method_field != 4'h0; // R8
  assign apb_setup  = ce && psel && !penable;
  assign apb_wr     = ce && psel && penable && pwrite;
  assign rezero_req = apb_wr && paddr == DHM_A_CMD && pwdata[DHM_CMD_REZERO] && mon_on;
  assign clear_req  = apb_wr && paddr == DHM_A_CMD && pwdata[DHM_CMD_CLEAR];
  assign ref_wr     = apb_wr && paddr == DHM_A_REFT;
  // Zero wait states: read data is captured in the setup cycle
  assign pready     = 1'b1;

  // Interval verdicts, computed per attribute from this cycle's strobes
  always_comb begin
    for (int i = 0; i < NUM_ATTR; i++) begin
      next_fail[i]   = CW'(fail_cnt[i] + CW'(err_strobe[i])); // R11
      verdict_end[i] = mon_on && op_strobe[i] && (CW'(intv_cnt[i] + 1'b1) >= CW'(iops)); // R10 R3
      verdict_bad[i] = next_fail[i] > CW'(fthr); // R12
      pred_new[i]    = mon_on && pthr != 8'h00 && HW'(pthr) <= hist_cnt[i] && !pred_flag[i];
    end
  end

  // Per-attribute interval, failure and history counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_ATTR; i++) begin
        intv_cnt[i] <= '0;
        fail_cnt[i] <= '0;
        hist_cnt[i] <= '0;
      end
    end else if (ce && mon_on) begin
      for (int i = 0; i < NUM_ATTR; i++) begin
        if (verdict_end[i]) begin
          intv_cnt[i] <= '0; // R13
          fail_cnt[i] <= '0; // R13
          hist_cnt[i] <= dhm_hist_next(hist_cnt[i], verdict_bad[i]); // R14
        end else begin
          intv_cnt[i] <= CW'(intv_cnt[i] + CW'(op_strobe[i])); // R10
          fail_cnt[i] <= (next_fail[i] == '0) ? fail_cnt[i] : next_fail[i]; // R11
        end
      end
    end
  end

  // Sticky predictive flags; a new crossing wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pred_flag <= '0;
    end else if (ce) begin
      pred_flag <= (clear_req ? '0 : pred_flag) | pred_new; // R15
    end
  end

  // One-second prescaler feeding the schedule and thermal timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= '0;
    end else if (ce) begin
      tick_div <= (tick_div == TW'(TICK_CYCLES - 1)) ? '0 : TW'(tick_div + 1'b1);
    end
  end
  assign tick = tick_div == TW'(TICK_CYCLES - 1);

  // Two-hour schedule; a forced pass restarts the countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sched_secs <= DHM_SCHED_TICKS;
      pass_pend  <= 1'b0;
    end else if (ce) begin
      if (rezero_req) begin
        sched_secs <= DHM_SCHED_TICKS; // R4
      end else if (tick && mon_on) begin
        sched_secs <= (sched_secs <= 13'h0001) ? DHM_SCHED_TICKS : 13'(sched_secs - 1'b1); // R6
      end
      // A new request wins over the launch that consumes the old one
      pass_pend <= (pass_pend && pass_state != DHM_P_WAIT) || rezero_req ||
                   (tick && mon_on && sched_secs <= 13'h0001); // R4 R6
    end
  end

  assign stall_hit = stall_cnt >= (ctrl.online_only_bit ? SW'(STALL_ONLINE) : SW'(STALL_FULL)); // R7

  // Pass sequencer: waits for idle interfaces, then cannot be cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_state   <= DHM_P_IDLE;
      stall_cnt    <= '0;
      meas_req     <= 1'b0;
      meas_offline <= 1'b0;
      stall_over   <= 1'b0;
    end else if (ce) begin
      if (clear_req) begin
        stall_over <= 1'b0;
      end
      unique case (pass_state)
        DHM_P_IDLE: begin
          if (pass_pend && mon_on) begin
            pass_state <= DHM_P_WAIT;
          end
        end
        DHM_P_WAIT: begin
          if (!mon_on) begin
            pass_state <= DHM_P_IDLE; // R1
          end else if (host_idle) begin
            pass_state   <= DHM_P_RUN; // R6
            stall_cnt    <= '0;
            meas_req     <= 1'b1;
            meas_offline <= !ctrl.online_only_bit; // R2
          end
        end
        DHM_P_RUN: begin
          // Uninterruptible: only completion or the stall bound ends it
          if (meas_done || stall_hit) begin
            pass_state <= DHM_P_IDLE; // R6
            meas_req   <= 1'b0;
            if (stall_hit && !meas_done) begin
              stall_over <= 1'b1; // R7
            end
          end else begin
            stall_cnt <= SW'(stall_cnt + 1'b1);
          end
        end
        default: pass_state <= DHM_P_IDLE;
      endcase
    end
  end

  // Thermal sampling at power-up and every ten minutes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_first <= 1'b1;
      temp_secs  <= DHM_TEMP_TICKS;
      temp_last  <= 8'h00;
      temp_warn  <= 1'b0;
    end else if (ce) begin
      temp_first <= 1'b0;
      if (tick) begin
        temp_secs <= (temp_secs <= 13'h0001) ? DHM_TEMP_TICKS : 13'(temp_secs - 1'b1);
      end
      if (temp_sample) begin
        temp_last <= temp_c;
      end
      if (temp_sample && ctrl.enable_temp_warning_bit &&
          (temp_c > DHM_TEMP_FIXED_C || temp_c > ref_temp)) begin
        temp_warn <= 1'b1; // R17 R19 R20 R22
      end else if (clear_req) begin
        temp_warn <= 1'b0;
      end
    end
  end
  assign temp_sample = temp_first || (tick && temp_secs <= 13'h0001); // R16

  // Sense reporting; restored from the nonvolatile copy after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_pend <= 1'b1;
      sense_valid  <= 1'b0;
      nv_sense_out <= '0;
      nv_save      <= 1'b0;
    end else if (ce) begin
      restore_pend <= 1'b0;
      nv_save      <= 1'b0;
      if (restore_pend) begin
        sense_valid  <= nv_valid_in; // R9
        nv_sense_out <= nv_sense_in; // R9
      end else if (report_en && |pred_new) begin
        sense_valid  <= 1'b1;
        nv_sense_out <= '{temp_last, DHM_KEY_RECOV, DHM_ASC_PRED, dhm_first_idx(pred_new)}; // R8
        nv_save      <= 1'b1; // R9
      end else if (report_en && temp_sample && ctrl.enable_temp_warning_bit &&
                   (temp_c > DHM_TEMP_FIXED_C || temp_c > ref_temp)) begin
        sense_valid  <= 1'b1;
        nv_sense_out <= '{temp_c, DHM_KEY_RECOV, DHM_ASC_TEMP, DHM_ASCQ_TEMP}; // R17 R18 R19
        nv_save      <= 1'b1;
      end else if (ref_wr && pwdata[7:0] > DHM_TEMP_FIXED_C) begin
        sense_valid  <= 1'b1;
        nv_sense_out <= '{temp_last, DHM_KEY_RECOV, DHM_ASC_ROUND, DHM_ASCQ_ZERO}; // R21
      end else if (clear_req) begin
        sense_valid  <= 1'b0;
        nv_save      <= 1'b1;
      end
    end
  end

  // Software-written control and threshold registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= DHM_CTRL_RST;
      iops       <= DHM_IOPS_RST;
      fthr       <= DHM_FTHR_RST;
      pthr       <= DHM_PTHR_RST;
      ref_temp   <= DHM_TEMP_FIXED_C;
      log_sel    <= 8'h00;
      clamp_flag <= 1'b0;
    end else if (apb_wr) begin
      unique case (paddr)
        DHM_A_CTRL:   ctrl <= pwdata[7:0];
        DHM_A_IOPS:   iops <= pwdata[15:0];
        DHM_A_FTHR:   fthr <= pwdata[15:0];
        DHM_A_PTHR:   pthr <= pwdata[7:0];
        DHM_A_LOGSEL: log_sel <= pwdata[7:0];
        DHM_A_REFT: begin
          // Values above the fixed limit are rounded down to it
          ref_temp   <= (pwdata[7:0] > DHM_TEMP_FIXED_C) ? DHM_TEMP_FIXED_C : pwdata[7:0]; // R21
          clamp_flag <= pwdata[7:0] > DHM_TEMP_FIXED_C; // R21
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets answer zero with an error
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (paddr)
      DHM_A_CTRL:   next_rdata = {24'h00_0000, ctrl};
      DHM_A_CMD:    next_rdata = 32'h0000_0000;
      DHM_A_IOPS:   next_rdata = {16'h0000, iops};
      DHM_A_FTHR:   next_rdata = {16'h0000, fthr};
      DHM_A_PTHR:   next_rdata = {24'h00_0000, pthr};
      DHM_A_REFT:   next_rdata = {24'h00_0000, ref_temp};
      DHM_A_SENSE:  next_rdata = nv_sense_out;
      DHM_A_STAT:   next_rdata = {8'h00, 8'(pred_flag), 8'(pass_state), 3'b000, sense_valid,
                                  stall_over, clamp_flag, temp_warn, pass_pend};
      DHM_A_LOGSEL: next_rdata = {24'h00_0000, log_sel};
      DHM_A_LOGDAT: begin
        if (log_sel == DHM_LOG_TIME) begin
          next_rdata = {19'h0_0000, sched_secs}; // R5
        end else if (log_sel == DHM_LOG_TEMP) begin
          next_rdata = {16'h0000, ref_temp, temp_last};
        end
      end
      default: next_err = 1'b1;
    endcase
  end

  // Read data and error are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
  end

  sequence s_rezero_hit;
    ce && rezero_req;
  endsequence

  sequence s_pass_busy;
    pass_state == DHM_P_RUN && !meas_done && !stall_hit;
  endsequence

  property p_rezero_restart;
    @(posedge pclk) disable iff (!presetn)
    s_rezero_hit |=> sched_secs == DHM_SCHED_TICKS && pass_pend;
  endproperty
  a_rezero_restart: assert property (p_rezero_restart) else $error("forced pass did not restart timer"); // R4

  property p_pass_hold;
    @(posedge pclk) disable iff (!presetn)
    s_pass_busy |=> pass_state == DHM_P_RUN && meas_req;
  endproperty
  a_pass_hold: assert property (p_pass_hold) else $error("pass ended early"); // R6

  property p_stall_end;
    @(posedge pclk) disable iff (!presetn)
    ce && pass_state == DHM_P_RUN && stall_hit && !meas_done |=> pass_state == DHM_P_IDLE && stall_over;
  endproperty
  a_stall_end: assert property (p_stall_end) else $error("stall bound not enforced"); // R7

  property p_disable_idle;
    @(posedge pclk) disable iff (!presetn)
    ce && ctrl.disable_exception_bit && pass_state != DHM_P_RUN |=> pass_state == DHM_P_IDLE;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("pass started while disabled"); // R1

  property p_verdict_clear;
    @(posedge pclk) disable iff (!presetn)
    ce && verdict_end[0] |=> intv_cnt[0] == '0 && fail_cnt[0] == '0;
  endproperty
  a_verdict_clear: assert property (p_verdict_clear) else $error("counters not cleared"); // R13

  property p_hist_up;
    @(posedge pclk) disable iff (!presetn)
    ce && verdict_end[0] && verdict_bad[0] && hist_cnt[0] != '1 |=>
      hist_cnt[0] == HW'($past(hist_cnt[0]) + 1'b1);
  endproperty
  a_hist_up: assert property (p_hist_up) else $error("history did not increment"); // R14

  property p_pred_flag;
    @(posedge pclk) disable iff (!presetn)
    ce && mon_on && !clear_req && pthr != 8'h00 && HW'(pthr) <= hist_cnt[0] |=> pred_flag[0];
  endproperty
  a_pred_flag: assert property (p_pred_flag) else $error("predictive flag missing"); // R15

  property p_pred_sense;
    @(posedge pclk) disable iff (!presetn)
    ce && !restore_pend && report_en && pred_new[0] |=> sense_valid && nv_sense_out.asc == DHM_ASC_PRED;
  endproperty
  a_pred_sense: assert property (p_pred_sense) else $error("predictive sense not reported"); // R8

  property p_temp_trip;
    @(posedge pclk) disable iff (!presetn)
    ce && temp_sample && ctrl.enable_temp_warning_bit && temp_c > DHM_TEMP_FIXED_C |=> temp_warn;
  endproperty
  a_temp_trip: assert property (p_temp_trip) else $error("fixed trip missed"); // R20

  property p_ref_clamp;
    @(posedge pclk) disable iff (!presetn)
    ref_wr && pwdata[7:0] > DHM_TEMP_FIXED_C |=> ref_temp == DHM_TEMP_FIXED_C && clamp_flag;
  endproperty
  a_ref_clamp: assert property (p_ref_clamp) else $error("reference not clamped"); // R21
endmodule
`default_nettype wire

// *** tb/dhm_far_model.sv ***
// Far-side model: measurement engine and nonvolatile sense store.
// Assumes it shares pclk with the monitor; the store ignores presetn.
`timescale 1ns/10ps
`default_nettype none
module dhm_far_model (
  input  wire logic                pclk,
  input  wire logic                slow,
  input  wire logic                meas_req,
  input  wire logic                nv_save,
  input  wire dhm_pkg::dhm_sense_s nv_sense_out,
  input  wire logic                sense_valid,
  output logic                     meas_done,
  output dhm_pkg::dhm_sense_s      nv_sense_in,
  output logic                     nv_valid_in
);
  import dhm_pkg::*;
  int cnt;
  // Empty store at power-up
  initial begin
    cnt = 0;
    meas_done = 1'b0;
    nv_sense_in = '0;
    nv_valid_in = 1'b0;
  end
  // Pass ends promptly, or so late that only the stall bound can end it
  always @(posedge pclk) begin
    meas_done <= 1'b0;
    if (!meas_req) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == (slow ? 200 : 5)) meas_done <= 1'b1;
    end
  end
  // Store is not touched by presetn, like a real nonvolatile part
  always @(posedge pclk) begin
    if (nv_save) begin
      nv_sense_in <= nv_sense_out;
      nv_valid_in <= sense_valid;
    end
  end
endmodule
`default_nettype wire

// *** tb/dhm_drive_health_monitor_tb.sv ***
// Self-checking bench for the drive health monitor over APB.
// Assumes short tick and stall parameters so passes and samples fit the run.
`timescale 1ns/10ps
`default_nettype none
module dhm_drive_health_monitor_tb;
  import dhm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_idle, slow;
  logic meas_req, meas_offline, meas_done, nv_save, sense_valid, stall_over, nv_valid_in;
  logic [7:0] paddr, temp_c;
  logic [31:0] pwdata, prdata, v;
  logic [3:0] op_strobe, err_strobe;
  dhm_sense_s nv_sense_in, nv_sense_out;
  int error_cnt, n_checks;
  dhm_drive_health_monitor #(.TICK_CYCLES(10), .STALL_ONLINE(20), .STALL_FULL(40)) i_dhm_drive_health_monitor (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_strobe(op_strobe), .err_strobe(err_strobe), .host_idle(host_idle), .meas_done(meas_done),
    .temp_c(temp_c), .nv_sense_in(nv_sense_in), .nv_valid_in(nv_valid_in), .meas_req(meas_req),
    .meas_offline(meas_offline), .nv_sense_out(nv_sense_out), .nv_save(nv_save),
    .sense_valid(sense_valid), .stall_over(stall_over));
  dhm_far_model i_dhm_far_model (.pclk(pclk), .slow(slow), .meas_req(meas_req), .nv_save(nv_save),
    .nv_sense_out(nv_sense_out), .sense_valid(sense_valid), .meas_done(meas_done),
    .nv_sense_in(nv_sense_in), .nv_valid_in(nv_valid_in));
  // Clock at 50 MHz
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
    v = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Bounded wait on a status bit or a port level
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && s !== lvl; n++) @(posedge pclk);
    if (s !== lvl) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // One interval's worth of ops on one attribute, errors on the first ones
  task automatic ops(input int at, input int n, input int ne);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      op_strobe <= 4'(1 << at); err_strobe <= (i < ne) ? 4'(1 << at) : 4'h0;
      @(posedge pclk);
      op_strobe <= 4'h0; err_strobe <= 4'h0;
    end
  endtask
  task automatic do_reset();
    @(posedge pclk) presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_reset();
    apb(0, DHM_A_CTRL, 0); chk(v, 32'h44);
    apb(0, DHM_A_REFT, 0); chk(v, 32'h41);
    apb(0, 8'h40, 0); chk({31'h0, pslverr}, 32'h1);
    $display("reset done");
  endtask
  task automatic t_clamp();
    apb(1, DHM_A_REFT, 32'h50); apb(0, DHM_A_REFT, 0); chk(v, 32'h41);
    apb(0, DHM_A_SENSE, 0); chk(v[23:0], 24'h013700);
    apb(1, DHM_A_REFT, 32'h20); apb(0, DHM_A_REFT, 0); chk(v, 32'h20);
    $display("clamp done");
  endtask
  task automatic t_temp();
    int n;
    // First pass trips the user point only, second trips both, as the user point then equals the fixed one
    for (int k = 0; k < 2; k++) begin
      apb(1, DHM_A_CMD, 32'h2);
      if (k == 1) apb(1, DHM_A_REFT, 32'h41);
      temp_c <= (k == 1) ? 8'h46 : 8'h28;
      for (n = 0; n < 2500; n++) begin
        apb(0, DHM_A_STAT, 0);
        if (v[1] === 1'b1) break;
      end
      chk({31'h0, v[1]}, 32'h1);
      chk(32'(n > 1500), 32'h1);
      apb(0, DHM_A_SENSE, 0); chk(v, (k == 1) ? 32'h46010B01 : 32'h28010B01);
    end
    $display("temp done");
  endtask
  task automatic t_rate();
    apb(1, DHM_A_CMD, 32'h2); apb(1, DHM_A_IOPS, 4); apb(1, DHM_A_FTHR, 1); apb(1, DHM_A_PTHR, 2);
    ops(2, 4, 2); ops(2, 4, 1); ops(2, 4, 2);
    apb(0, DHM_A_STAT, 0); chk(v[23:16], 8'h00);
    ops(2, 4, 2); ops(2, 3, 0);
    apb(0, DHM_A_STAT, 0); chk(v[23:16], 8'h04);
    apb(0, DHM_A_SENSE, 0); chk(v[23:0], 24'h015D02);
    $display("rate done");
  endtask
  task automatic t_retain();
    do_reset();
    repeat (3) @(posedge pclk);
    apb(0, DHM_A_SENSE, 0); chk(v[23:0], 24'h015D02);
    chk({31'h0, sense_valid}, 32'h1);
    $display("retain done");
  endtask
  task automatic t_pass();
    host_idle <= 1'b0;
    apb(1, DHM_A_CMD, 32'h1); apb(0, DHM_A_STAT, 0); chk(v[15:8], 8'h01);
    chk({31'h0, meas_req}, 32'h0);
    host_idle <= 1'b1;
    wait_lvl(meas_req, 1'b1, 20);
    chk({31'h0, meas_offline}, 32'h1);
    wait_lvl(meas_req, 1'b0, 50);
    apb(1, DHM_A_LOGSEL, 32'h3E); apb(0, DHM_A_LOGDAT, 0); chk(32'(v >= 7190 && v <= 7200), 32'h1);
    apb(1, DHM_A_LOGSEL, 32'h0D); apb(0, DHM_A_LOGDAT, 0); chk(v, 32'h00004146);
    slow <= 1'b1;
    apb(1, DHM_A_CTRL, 32'h46); apb(1, DHM_A_CMD, 32'h1);
    wait_lvl(meas_req, 1'b1, 20);
    chk({31'h0, meas_offline}, 32'h0);
    wait_lvl(meas_req, 1'b0, 40);
    chk({31'h0, stall_over}, 32'h1);
    $display("pass done");
  endtask
  task automatic t_disable();
    slow <= 1'b0;
    apb(1, DHM_A_CTRL, 32'h45); apb(1, DHM_A_CMD, 32'h2); apb(1, DHM_A_IOPS, 2); apb(1, DHM_A_PTHR, 1);
    ops(1, 2, 2); ops(1, 2, 2);
    apb(1, DHM_A_CMD, 32'h1); apb(0, DHM_A_STAT, 0);
    chk(v[23:16], 8'h00);
    chk(v[15:8], 8'h00);
    $display("disable done");
  endtask
  // Main sequence
  initial begin
    error_cnt = 0; n_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    op_strobe = 4'h0; err_strobe = 4'h0; host_idle = 1'b1; temp_c = 8'h19; slow = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(); t_clamp(); t_temp(); t_rate(); t_retain(); t_pass(); t_disable();
    stop_test();
  end
endmodule
`default_nettype wire
